// ==== src/display_fifo_fifo_test_access_enable_pkg.sv ====
// Constants, register map and a helper function for the display FIFO test access block.
package display_fifo_fifo_test_access_enable_pkg;

  // ==========================================================================
  // Widths and depths
  // ==========================================================================
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 32;
  localparam int DISP_W   = 64;
  localparam int PTR_W    = 4;
  localparam int CTRL_W   = 4;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [ADDR_W-1:0] OFF_DISP_PORT = 16'h8378;
  localparam logic [ADDR_W-1:0] OFF_COMP_PORT = 16'h837C;
  localparam logic [ADDR_W-1:0] OFF_CTRL      = 16'h8380;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 16'h8384;

  // ==========================================================================
  // Control register fields and reset value
  // ==========================================================================
  localparam int BIT_TEST_EN     = 0;
  localparam int BIT_LOAD_EN     = 1;
  localparam int BIT_OUT_TEST_EN = 2;
  localparam int BIT_READ_SEL    = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h2;

  // ==========================================================================
  // Status register fields
  // ==========================================================================
  localparam int STAT_DISP_WPTR = 0;
  localparam int STAT_DISP_RPTR = 4;
  localparam int STAT_COMP_WPTR = 8;
  localparam int STAT_COMP_RPTR = 12;
  localparam int STAT_DISP_WHALF = 16;
  localparam int STAT_DISP_RHALF = 17;
  localparam int STAT_DISP_PRIMED = 18;
  localparam int STAT_COMP_PRIMED = 19;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [PTR_W-1:0] ptrInc(input logic [PTR_W-1:0] ptr);
    ptrInc = ptr + 4'h1;
  endfunction

endpackage

// ==== src/fifo_test_ram.sv ====
// Flip-flop storage array with one write port and one combinational read port.
`timescale 1ns/1ps
module fifo_test_ram #(
  parameter int WIDTH = 32,
  parameter int PTR_W = 4
) (
  input  wire logic             clk,
  input  wire logic             wrEn,
  input  wire logic [PTR_W-1:0] wrIdx,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [PTR_W-1:0] rdIdx,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] mem [2**PTR_W];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  assign rdData = mem[rdIdx];

endmodule

// ==== src/display_fifo_fifo_test_access_enable_access.sv ====
// Software test access to the display pixel FIFO and the compressed-data FIFO.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
// Function
// [RULE1] Software sets test enable and clears display load enable before display port access.
// [RULE2] Software writes the display port an even number of times.
// [RULE3] Display write pointer advances after every second display port write.
// [RULE4] One ignored read loads the output latch; later reads return written data in order.
// [RULE5] Display read pointer advances after every second data read.
// [RULE6] Software leaves at least four clocks between display port reads.
// [RULE7] Compressed access needs both test enables set and load enable clear; writes also need read select clear.
// [RULE8] Compressed write pointer advances after every compressed port write.
// [RULE9] Read select high, then one ignored read loads latch; later reads return data.
// [RULE10] Compressed read pointer advances after every compressed port read.
// [RULE11] With test enable low, port accesses leave every FIFO pointer untouched.
module display_fifo_fifo_test_access_enable_access (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStrobe,
  input  wire logic        regRdStrobe,
  output logic      [31:0] regRdData
);

  // ==========================================================================
  // Control register and access qualification
  // ==========================================================================
  logic [display_fifo_fifo_test_access_enable_pkg::CTRL_W-1:0]  ctrl_q;
  logic                                      dispOk;
  logic                                      compOk;
  logic                                      dispWr;
  logic                                      dispRd;
  logic                                      compWr;
  logic                                      compRd;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= display_fifo_fifo_test_access_enable_pkg::CTRL_RESET;
    end else if (regWrStrobe && regAddr == display_fifo_fifo_test_access_enable_pkg::OFF_CTRL) begin
      ctrl_q <= regWrData[display_fifo_fifo_test_access_enable_pkg::CTRL_W-1:0];
    end
  end

  // Accesses outside test mode belong to the refresh path and are ignored.
  assign dispOk = ctrl_q[display_fifo_fifo_test_access_enable_pkg::BIT_TEST_EN] && !ctrl_q[display_fifo_fifo_test_access_enable_pkg::BIT_LOAD_EN]; // see [RULE11]
  assign compOk = dispOk && ctrl_q[display_fifo_fifo_test_access_enable_pkg::BIT_OUT_TEST_EN];
  assign dispWr = regWrStrobe && regAddr == display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT && dispOk;
  assign dispRd = regRdStrobe && regAddr == display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT && dispOk;
  // The read select steers the compressed port between write and read addressing.
  assign compWr = regWrStrobe && regAddr == display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT && compOk
                  && !ctrl_q[display_fifo_fifo_test_access_enable_pkg::BIT_READ_SEL]; // see [RULE9]
  assign compRd = regRdStrobe && regAddr == display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT && compOk
                  && ctrl_q[display_fifo_fifo_test_access_enable_pkg::BIT_READ_SEL]; // see [RULE9]

  // ==========================================================================
  // Display FIFO
  // ==========================================================================
  logic [display_fifo_fifo_test_access_enable_pkg::PTR_W-1:0]  dispWrPtr_q;
  logic [display_fifo_fifo_test_access_enable_pkg::PTR_W-1:0]  dispRdPtr_q;
  logic                                     dispWrHalf_q;
  logic                                     dispRdHalf_q;
  logic                                     dispPrimed_q;
  logic [31:0]                              dispLow_q;
  logic [display_fifo_fifo_test_access_enable_pkg::DISP_W-1:0] dispLatch_q;
  logic [display_fifo_fifo_test_access_enable_pkg::DISP_W-1:0] dispRamOut;
  logic                                     dispRamWr;
  logic                                     dispLoad;

  assign dispRamWr = dispWr && dispWrHalf_q;
  // The latch reloads on the priming read and after the upper word is read.
  assign dispLoad  = dispRd && (!dispPrimed_q || dispRdHalf_q);

  fifo_test_ram #(
    .WIDTH (display_fifo_fifo_test_access_enable_pkg::DISP_W),
    .PTR_W (display_fifo_fifo_test_access_enable_pkg::PTR_W)
  ) dispRam (
    .clk    (clk),
    .wrEn   (dispRamWr),
    .wrIdx  (dispWrPtr_q),
    .wrData ({regWrData, dispLow_q}),
    .rdIdx  (dispRdPtr_q),
    .rdData (dispRamOut)
  );

  // First write of a pair is held as the low word; the second completes the entry.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dispWrPtr_q  <= 4'h0;
      dispWrHalf_q <= 1'b0;
      dispLow_q    <= 32'h0000_0000;
    end else if (dispWr) begin
      dispWrHalf_q <= !dispWrHalf_q;
      if (!dispWrHalf_q) begin
        dispLow_q <= regWrData;
      end else begin
        dispWrPtr_q <= display_fifo_fifo_test_access_enable_pkg::ptrInc(dispWrPtr_q); // see [RULE3]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dispRdPtr_q  <= 4'h0;
      dispRdHalf_q <= 1'b0;
      dispPrimed_q <= 1'b0;
      dispLatch_q  <= 64'h0000_0000_0000_0000;
    end else begin
      if (dispWr) begin
        dispPrimed_q <= 1'b0;
        dispRdHalf_q <= 1'b0;
      end else if (dispRd) begin
        dispPrimed_q <= 1'b1; // see [RULE4]
        dispRdHalf_q <= dispPrimed_q && !dispRdHalf_q;
      end
      if (dispLoad) begin
        dispLatch_q <= dispRamOut; // see [RULE4]
        dispRdPtr_q <= display_fifo_fifo_test_access_enable_pkg::ptrInc(dispRdPtr_q); // see [RULE5]
      end
    end
  end

  // ==========================================================================
  // Compressed FIFO
  // ==========================================================================
  logic [display_fifo_fifo_test_access_enable_pkg::PTR_W-1:0] compWrPtr_q;
  logic [display_fifo_fifo_test_access_enable_pkg::PTR_W-1:0] compRdPtr_q;
  logic                                    compPrimed_q;
  logic [31:0]                             compLatch_q;
  logic [31:0]                             compRamOut;

  fifo_test_ram #(
    .WIDTH (display_fifo_fifo_test_access_enable_pkg::DATA_W),
    .PTR_W (display_fifo_fifo_test_access_enable_pkg::PTR_W)
  ) compRam (
    .clk    (clk),
    .wrEn   (compWr),
    .wrIdx  (compWrPtr_q),
    .wrData (regWrData),
    .rdIdx  (compRdPtr_q),
    .rdData (compRamOut)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compWrPtr_q <= 4'h0;
    end else if (compWr) begin
      compWrPtr_q <= display_fifo_fifo_test_access_enable_pkg::ptrInc(compWrPtr_q); // see [RULE8]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compRdPtr_q  <= 4'h0;
      compPrimed_q <= 1'b0;
      compLatch_q  <= 32'h0000_0000;
    end else if (compWr) begin
      compPrimed_q <= 1'b0;
    end else if (compRd) begin
      compPrimed_q <= 1'b1; // see [RULE9]
      compLatch_q  <= compRamOut;
      compRdPtr_q  <= display_fifo_fifo_test_access_enable_pkg::ptrInc(compRdPtr_q); // see [RULE10]
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [31:0] status;

  always_comb begin
    status = 32'h0000_0000;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_DISP_WPTR +: 4] = dispWrPtr_q;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_DISP_RPTR +: 4] = dispRdPtr_q;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_COMP_WPTR +: 4] = compWrPtr_q;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_COMP_RPTR +: 4] = compRdPtr_q;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_DISP_WHALF]    = dispWrHalf_q;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_DISP_RHALF]    = dispRdHalf_q;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_DISP_PRIMED]   = dispPrimed_q;
    status[display_fifo_fifo_test_access_enable_pkg::STAT_COMP_PRIMED]   = compPrimed_q;
  end

  // The priming read and any refused or unmapped read return zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else begin
      regRdData <= 32'h0000_0000;
      if (regRdStrobe) begin
        unique case (regAddr)
          display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT: begin
            if (dispRd && dispPrimed_q) begin
              regRdData <= dispRdHalf_q ? dispLatch_q[63:32] : dispLatch_q[31:0]; // see [RULE4]
            end
          end
          display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT: begin
            if (compRd && compPrimed_q) begin
              regRdData <= compLatch_q; // see [RULE9]
            end
          end
          display_fifo_fifo_test_access_enable_pkg::OFF_CTRL: begin
            regRdData <= {28'h000_0000, ctrl_q};
          end
          display_fifo_fifo_test_access_enable_pkg::OFF_STATUS: begin
            regRdData <= status;
          end
          default: begin
            regRdData <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_disp_wr_pair: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE3]
    dispWr && dispWrHalf_q |=> dispWrPtr_q == display_fifo_fifo_test_access_enable_pkg::ptrInc($past(dispWrPtr_q)) && !dispWrHalf_q)
    else $error("display write pointer did not step after second write");

  chk_disp_wr_hold: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE3]
    dispWr && !dispWrHalf_q |=> $stable(dispWrPtr_q) && dispWrHalf_q)
    else $error("display write pointer moved on first write of a pair");

  chk_disp_prime_zero: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE4]
    dispRd && !dispPrimed_q |=> dispPrimed_q && regRdData == 32'h0000_0000 && dispLatch_q == $past(dispRamOut))
    else $error("priming read did not load the display latch");

  chk_disp_rd_order: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE4]
    dispRd && dispPrimed_q && !dispRdHalf_q |=> regRdData == $past(dispLatch_q[31:0]) && $stable(dispRdPtr_q))
    else $error("display low word read back wrong");

  chk_disp_rd_pair: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE5]
    dispRd && dispPrimed_q && dispRdHalf_q |=> regRdData == $past(dispLatch_q[63:32])
      && dispRdPtr_q == display_fifo_fifo_test_access_enable_pkg::ptrInc($past(dispRdPtr_q)))
    else $error("display read pointer did not step after second read");

  chk_comp_wr_step: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE8]
    compWr |=> compWrPtr_q == display_fifo_fifo_test_access_enable_pkg::ptrInc($past(compWrPtr_q)))
    else $error("compressed write pointer did not step");

  chk_comp_sel_gate: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE9]
    regWrStrobe && regAddr == display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT && ctrl_q[display_fifo_fifo_test_access_enable_pkg::BIT_READ_SEL]
      |=> $stable(compWrPtr_q))
    else $error("compressed write taken while read select high");

  chk_comp_rd_step: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE10]
    compRd |=> compRdPtr_q == display_fifo_fifo_test_access_enable_pkg::ptrInc($past(compRdPtr_q))
      && regRdData == ($past(compPrimed_q) ? $past(compLatch_q) : 32'h0000_0000))
    else $error("compressed read pointer or data wrong");

  chk_idle_frozen: assert property (@(posedge clk) disable iff (!rst_n) // see [RULE11]
    !ctrl_q[display_fifo_fifo_test_access_enable_pkg::BIT_TEST_EN] |=> $stable(dispWrPtr_q) && $stable(dispRdPtr_q)
      && $stable(compWrPtr_q) && $stable(compRdPtr_q))
    else $error("FIFO pointer moved outside test mode");

endmodule

// ==== testbench/tb_display_fifo_fifo_test_access_enable_access.sv ====
// Self-checking testbench for the display FIFO test access block.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin numChecks++; if ((got) !== (exp)) begin nFail++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module tb_display_fifo_fifo_test_access_enable_access;
  logic        clk;
  logic        rst_n;
  logic [15:0] regAddr;
  logic [31:0] regWrData;
  logic        regWrStrobe;
  logic        regRdStrobe;
  logic [31:0] regRdData;
  int          nFail;
  int          numChecks;

  display_fifo_fifo_test_access_enable_access dut (
    .clk         (clk),
    .rst_n       (rst_n),
    .regAddr     (regAddr),
    .regWrData   (regWrData),
    .regWrStrobe (regWrStrobe),
    .regRdStrobe (regRdStrobe),
    .regRdData   (regRdData)
  );

  always #4 clk = ~clk;

  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(posedge clk);
    regWrStrobe <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
  task automatic rdChk(input logic [15:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    @(posedge clk);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(posedge clk);
    regRdStrobe <= 1'b0;
    #1;
    d = regRdData;
    `CHK(what, exp, d)
  endtask

  task automatic gap4();
    repeat (4) @(posedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic resetAndRefusal();
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_0002, "ctrl reset");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0000_0000, "status reset");
    wr(16'h8390, 32'hFFFF_FFFF);
    rdChk(16'h8390, 32'h0000_0000, "unmapped");
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h1234_5678);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h9ABC_DEF0);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h0000_0000, "disp refused");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0000_0000, "status test off");
  endtask

  task automatic displayFifo();
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_0001);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'hA1B2_C3D4);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h0F1E_2D3C);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h5566_7788);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0001_0001, "disp wptr odd");
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'hCAFE_F00D);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0000_0002, "disp wptr even");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h0000_0000, "disp prime");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0004_0012, "disp primed");
    gap4();
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'hA1B2_C3D4, "disp word0");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0006_0012, "disp rptr half");
    gap4();
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h0F1E_2D3C, "disp word1");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0004_0022, "disp rptr step");
    gap4();
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h5566_7788, "disp word2");
    gap4();
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'hCAFE_F00D, "disp word3");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0004_0032, "disp rptr end");
  endtask

  task automatic compressedFifo();
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_0005);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h1357_9BDF);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0004_0132, "comp wptr one");
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h2468_ACE0);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h0000_0000, "comp rd no sel");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h0004_0232, "comp wptr two");
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_000D);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'hDEAD_BEEF);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h0000_0000, "comp prime");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h000C_1232, "comp primed");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h1357_9BDF, "comp word0");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h2468_ACE0, "comp word1");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h000C_3232, "comp rptr end");
  endtask

  // Load enable set must refuse both ports; output test enable clear must refuse the compressed port.
  task automatic testOffAgain();
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_0007);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h0BAD_0BAD);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h0BAD_0BAD);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h0000_0000, "disp load on");
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_0001);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h0BAD_0BAD);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h000C_3232, "status refused");
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_0000);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_CTRL, 32'h0000_0000, "ctrl readback");
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_DISP_PORT, 32'h0BAD_0BAD);
    wr(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h0BAD_0BAD);
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_COMP_PORT, 32'h0000_0000, "comp test off");
    rdChk(display_fifo_fifo_test_access_enable_pkg::OFF_STATUS, 32'h000C_3232, "status frozen");
  endtask

  // ==========================================================================
  // Verdict and main sequence
  // ==========================================================================
  task automatic giveVerdict();
    if (nFail == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    nFail++;
    giveVerdict();
  end

  initial begin
    clk         = 1'b0;
    rst_n       = 1'b0;
    regAddr     = 16'h0000;
    regWrData   = 32'h0000_0000;
    regWrStrobe = 1'b0;
    regRdStrobe = 1'b0;
    nFail       = 0;
    numChecks   = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    resetAndRefusal();
    displayFifo();
    compressedFifo();
    testOffAgain();
    giveVerdict();
  end
endmodule
